/* design/param_channel_device.sv */
`timescale 1ns/1ps
module param_channel_device import param_channel_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	param_channel_if.device ch,
	input wire logic know_how_lock_i,
	input wire logic master_control_setting_i,
	input wire logic [7:0] commissioning_state_setting_i,
	input wire logic drive_enabled_i,
	input wire logic op_state_busy_i,
	input wire logic keyword_present_i,
	input wire logic access_code_ok_i,
	input wire logic alt_mode_i,
	output logic [7:0] last_error_o,
	output logic write_pulse_o
);
	dev_state_t state_reg, state_next;
	logic req_ready_reg;
	logic [15:0] hdr_reg, idx_reg, vh_reg, vl_reg;
	logic rsp_valid_reg;
	logic [15:0] rsp_hdr_reg, rsp_idx_reg, rsp_hi_reg, rsp_lo_reg;
	logic [7:0] last_error_reg;
	logic write_pulse_reg;
	logic [31:0] store_reg [N_PARAMS][MAX_ELEMS];
	////////////////////////////////////////////////////////////////
	// request field decode
	logic [3:0] task_id;
	logic [10:0] param_number_field;
	logic [7:0] sub, page;
	logic [31:0] val;
	logic [15:0] num;
	logic num_ok;
	assign task_id = hdr_reg[TASK_MSB:TASK_LSB]; // R23
	assign param_number_field = hdr_reg[PNU_MSB:0];
	assign sub = idx_reg[SUB_MSB:SUB_LSB]; // R19
	assign page = idx_reg[PAGE_MSB:0]; // R17
	assign val = {vh_reg, vl_reg};
	param_number_codec u_codec (
		.pnu_i(param_number_field),
		.page_i(page),
		.num_i(16'h0000),
		.num_o(num),
		.num_ok_o(num_ok),
		.pnu_o(),
		.page_o(),
		.pnu_ok_o()
	);
	logic [N_PARAMS-1:0] hit;
	genvar g;
	generate
		for (g = 0; g < N_PARAMS; g++) begin : g_lookup
			assign hit[g] = num_ok && (num == PARAMS[g].num);
		end
	endgenerate
	logic [2:0] sel;
	always_comb begin
		sel = 3'h0;
		for (int i = N_PARAMS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				sel = 3'(i);
			end
		end
	end
	attr_t attr;
	logic found, is_change, any_change, wr_dword, task_ok, indexed;
	logic [1:0] elem;
	assign attr = PARAMS[sel];
	assign found = |hit;
	assign indexed = attr.elems != 3'h0;
	assign elem = indexed ? sub[1:0] : 2'h0;
	assign wr_dword = (task_id == TASK_WR_DWORD) || (task_id == TASK_WR_FIELD_DWORD);
	assign is_change = wr_dword || (task_id == TASK_WR_WORD) || (task_id == TASK_WR_FIELD_WORD);
	assign any_change = is_change || (task_id == TASK_WR_DESC);
	assign task_ok = (task_id <= TASK_READ_COUNT); // R11
	////////////////////////////////////////////////////////////////
	// individual checks
	logic sub_scalar_bad, sub_range_bad, desc_wide, type_bad, conn_bad, abs_bad;
	logic uses_sub;
	assign uses_sub = (task_id != TASK_READ_DESC) && (task_id != TASK_READ_COUNT) && (task_id != TASK_WR_DESC);
	assign sub_scalar_bad = uses_sub && !indexed && (sub != 8'h00); // R2
	assign sub_range_bad = uses_sub && indexed && (sub >= {5'h00, attr.elems}); // R2
	assign desc_wide = (task_id == TASK_READ_DESC) && (sub >= DESC_ELEMS); // R9
	assign type_bad = (attr.dtype == DT_DWORD && !wr_dword) || (attr.dtype != DT_DWORD && attr.dtype != DT_CONN
		&& wr_dword) || (attr.dtype == DT_BYTE && val[31:8] != 24'h000000) || (attr.dtype == DT_WORD
		&& vh_reg != 16'h0000); // R3 R20
	assign conn_bad = (attr.dtype == DT_CONN) && (vl_reg[15:CONN_TAG_LSB] != CONN_TAG); // R10 R21
	assign abs_bad = (attr.dtype != DT_CONN) && (val < attr.abs_lo || val > attr.abs_hi);
	////////////////////////////////////////////////////////////////
	// error priority
	logic err_hit;
	logic [7:0] err_code;
	always_comb begin
		err_hit = 1'b1;
		err_code = ERR_NO_PARAM;
		if (task_id == TASK_NONE) begin
			err_hit = 1'b0;
		end else if (!task_ok) begin
			err_code = ERR_TASK; // R11 R24
		end else if (know_how_lock_i) begin
			err_code = ERR_KNOW_HOW; // R14
		end else if (!found) begin
			err_code = ERR_NO_PARAM; // R1
		end else if (attr.deact && alt_mode_i) begin
			err_code = ERR_DEACTIVATED; // R8
		end else if (op_state_busy_i) begin
			err_code = ERR_OP_STATE; // R6
		end else if (sub_scalar_bad) begin
			err_code = ERR_NO_ARRAY; // R2
		end else if (sub_range_bad) begin
			err_code = ERR_SUBINDEX; // R2
		end else if (desc_wide) begin
			err_code = ERR_WIDTH; // R9
		end else if (!any_change) begin
			err_hit = 1'b0;
		end else if (!master_control_setting_i) begin
			err_code = ERR_NO_MASTER; // R5
		end else if (!keyword_present_i) begin
			err_code = ERR_NO_KEYWORD; // R6
		end else if (task_id == TASK_WR_DESC) begin
			err_code = ERR_DESC_RO; // R4
		end else if (!attr.wr) begin
			err_code = ERR_READ_ONLY; // R1
		end else if (attr.code_req && !access_code_ok_i) begin
			err_code = ERR_ACCESS; // R16
		end else if (attr.comm_only && commissioning_state_setting_i != COMM_STATE_OK) begin
			err_code = ERR_COMMISSION; // R13
		end else if (attr.stop_only && drive_enabled_i) begin
			err_code = ERR_ENABLED; // R12
		end else if (type_bad) begin
			err_code = ERR_TYPE; // R3
		end else if (attr.rst_only && val != 32'h00000000) begin
			err_code = ERR_RESET_ONLY; // R3
		end else if (conn_bad) begin
			err_code = ERR_ILLEGAL; // R10
		end else if (abs_bad) begin
			err_code = ERR_LIMIT; // R1
		end else if (attr.even && val[0]) begin
			err_code = ERR_BAD_VALUE; // R7
		end else if (attr.dtype != DT_CONN && val < attr.cur_lo) begin
			err_code = ERR_BELOW; // R15
		end else if (attr.dtype != DT_CONN && val > attr.cur_hi) begin
			err_code = ERR_ABOVE; // R15
		end else begin
			err_hit = 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// response assembly
	logic [31:0] rd_val;
	logic wide;
	logic [3:0] rsp_task;
	logic [31:0] rsp_val;
	assign rd_val = store_reg[sel][elem];
	assign wide = (attr.dtype == DT_DWORD) || (attr.dtype == DT_CONN);
	always_comb begin
		rsp_task = RSP_NONE;
		rsp_val = 32'h00000000;
		if (err_hit) begin
			rsp_task = RSP_ERROR; // R22
			rsp_val = {8'h00, err_code, 16'h0000}; // R22
		end else begin
			unique case (task_id)
				TASK_NONE: rsp_task = RSP_NONE;
				TASK_READ: begin
					rsp_task = wide ? RSP_DWORD : RSP_WORD;
					rsp_val = rd_val;
				end
				TASK_READ_FIELD: begin
					rsp_task = wide ? RSP_FIELD_DWORD : RSP_FIELD_WORD;
					rsp_val = rd_val;
				end
				TASK_READ_DESC: begin
					rsp_task = RSP_DESC;
					rsp_val = sub[0] ? attr.abs_hi : attr.abs_lo;
				end
				TASK_READ_COUNT: begin
					rsp_task = RSP_COUNT;
					rsp_val = {29'h00000000, attr.elems};
				end
				TASK_WR_WORD: begin
					rsp_task = RSP_WORD;
					rsp_val = val;
				end
				TASK_WR_DWORD: begin
					rsp_task = RSP_DWORD;
					rsp_val = val;
				end
				TASK_WR_FIELD_WORD: begin
					rsp_task = RSP_FIELD_WORD;
					rsp_val = val;
				end
				default: begin
					rsp_task = RSP_FIELD_DWORD;
					rsp_val = val;
				end
			endcase
		end
	end
	logic do_write;
	assign do_write = (state_reg == DEV_CHECK) && is_change && !err_hit;
	////////////////////////////////////////////////////////////////
	// sequencing
	logic req_take, rsp_take;
	assign req_take = ch.req_valid && req_ready_reg;
	assign rsp_take = rsp_valid_reg && ch.rsp_ready;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			DEV_IDLE: if (req_take) state_next = DEV_CHECK;
			DEV_CHECK: state_next = DEV_RESP;
			DEV_RESP: if (rsp_take) state_next = DEV_IDLE; // R24
			default: state_next = DEV_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= DEV_IDLE;
			req_ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			{hdr_reg, idx_reg, vh_reg, vl_reg} <= 64'h0;
			{rsp_hdr_reg, rsp_idx_reg, rsp_hi_reg, rsp_lo_reg} <= 64'h0;
			last_error_reg <= 8'h00;
			write_pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_ready_reg <= (state_next == DEV_IDLE);
			rsp_valid_reg <= (state_next == DEV_RESP);
			write_pulse_reg <= do_write;
			if (req_take) begin
				{hdr_reg, idx_reg, vh_reg, vl_reg} <= {ch.req_header, ch.req_index, ch.req_value_high,
					ch.req_value_low};
			end
			if (state_reg == DEV_CHECK) begin
				rsp_hdr_reg <= {rsp_task, 1'b0, param_number_field}; // R23
				rsp_idx_reg <= idx_reg;
				{rsp_hi_reg, rsp_lo_reg} <= rsp_val;
				if (err_hit) last_error_reg <= err_code;
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int p = 0; p < N_PARAMS; p++) begin
				for (int e = 0; e < MAX_ELEMS; e++) begin
					store_reg[p][e] <= PARAMS[p].cur_lo;
				end
			end
		end else if (do_write) begin
			store_reg[sel][elem] <= val;
		end
	end
	assign ch.req_ready = req_ready_reg;
	assign ch.rsp_valid = rsp_valid_reg;
	assign ch.rsp_header = rsp_hdr_reg;
	assign ch.rsp_index = rsp_idx_reg;
	assign ch.rsp_value_high = rsp_hi_reg;
	assign ch.rsp_value_low = rsp_lo_reg;
	assign last_error_o = last_error_reg;
	assign write_pulse_o = write_pulse_reg;
endmodule : param_channel_device

/* design/param_channel_pkg.sv */
// Notes on behaviour
// [R1] unknown number 00, fixed value 01, limits 02
// [R2] missing subindex 03, subindex on scalar 04
// [R3] wrong data type 05, reset only 06
// [R4] change of descriptive element gives 07
// [R5] change without master control gives 0B
// [R6] keyword missing 0C, busy operating state 11
// [R7] value not among permitted values gives 14
// [R8] number deactivated in present mode gives 65
// [R9] response too wide for channel gives 66
// [R10] value parameter cannot take gives 68
// [R11] unsupported task identifier gives 6A
// [R12] change while drive enabled gives 6B
// [R13] commissioning write outside state 15 gives 86
// [R14] know-how protection locks access, gives 87
// [R15] inside absolute, outside current limits: C8/C9
// [R16] change without access code gives CC
// [R17] page index in index word bits 7..0
// [R18] full number is page base plus 0..1999
// [R19] element index in index word bits 15..8
// [R20] 8, 16 or 32 bit value word layout
// [R21] connector: number, 3F tag, index bits
// [R22] failure answers identifier 7, code in high word
// [R23] task identifier in header bits 15..12
// [R24] one response per request, fixed error priority
package param_channel_pkg;
	localparam logic [3:0] TASK_NONE = 4'h0;
	localparam logic [3:0] TASK_READ = 4'h1;
	localparam logic [3:0] TASK_WR_WORD = 4'h2;
	localparam logic [3:0] TASK_WR_DWORD = 4'h3;
	localparam logic [3:0] TASK_READ_DESC = 4'h4;
	localparam logic [3:0] TASK_WR_DESC = 4'h5;
	localparam logic [3:0] TASK_READ_FIELD = 4'h6;
	localparam logic [3:0] TASK_WR_FIELD_WORD = 4'h7;
	localparam logic [3:0] TASK_WR_FIELD_DWORD = 4'h8;
	localparam logic [3:0] TASK_READ_COUNT = 4'h9;
	localparam logic [3:0] RSP_NONE = 4'h0;
	localparam logic [3:0] RSP_WORD = 4'h1;
	localparam logic [3:0] RSP_DWORD = 4'h2;
	localparam logic [3:0] RSP_DESC = 4'h3;
	localparam logic [3:0] RSP_FIELD_WORD = 4'h4;
	localparam logic [3:0] RSP_FIELD_DWORD = 4'h5;
	localparam logic [3:0] RSP_COUNT = 4'h6;
	localparam logic [3:0] RSP_ERROR = 4'h7;
	localparam logic [7:0] ERR_NO_PARAM = 8'h00;
	localparam logic [7:0] ERR_READ_ONLY = 8'h01;
	localparam logic [7:0] ERR_LIMIT = 8'h02;
	localparam logic [7:0] ERR_SUBINDEX = 8'h03;
	localparam logic [7:0] ERR_NO_ARRAY = 8'h04;
	localparam logic [7:0] ERR_TYPE = 8'h05;
	localparam logic [7:0] ERR_RESET_ONLY = 8'h06;
	localparam logic [7:0] ERR_DESC_RO = 8'h07;
	localparam logic [7:0] ERR_NO_MASTER = 8'h0b;
	localparam logic [7:0] ERR_NO_KEYWORD = 8'h0c;
	localparam logic [7:0] ERR_OP_STATE = 8'h11;
	localparam logic [7:0] ERR_BAD_VALUE = 8'h14;
	localparam logic [7:0] ERR_DEACTIVATED = 8'h65;
	localparam logic [7:0] ERR_WIDTH = 8'h66;
	localparam logic [7:0] ERR_ILLEGAL = 8'h68;
	localparam logic [7:0] ERR_TASK = 8'h6a;
	localparam logic [7:0] ERR_ENABLED = 8'h6b;
	localparam logic [7:0] ERR_COMMISSION = 8'h86;
	localparam logic [7:0] ERR_KNOW_HOW = 8'h87;
	localparam logic [7:0] ERR_BELOW = 8'hc8;
	localparam logic [7:0] ERR_ABOVE = 8'hc9;
	localparam logic [7:0] ERR_ACCESS = 8'hcc;
	localparam int TASK_MSB = 15;
	localparam int TASK_LSB = 12;
	localparam int PNU_MSB = 10;
	localparam int SUB_MSB = 15;
	localparam int SUB_LSB = 8;
	localparam int PAGE_MSB = 7;
	localparam int CONN_TAG_LSB = 10;
	localparam logic [5:0] CONN_TAG = 6'h3f;
	localparam logic [10:0] PNU_MAX = 11'h7cf;
	localparam logic [7:0] COMM_STATE_OK = 8'h0f;
	localparam logic [7:0] DESC_ELEMS = 8'h02;
	localparam int PAGE_COUNT = 8;
	localparam logic [7:0] PAGE_CODE [PAGE_COUNT] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'ha0, 8'h50, 8'hf0, 8'h74};
	localparam logic [15:0] PAGE_BASE [PAGE_COUNT] = '{16'h0000, 16'h07d0, 16'h1770, 16'h1f40, 16'h2710,
		16'h4e20, 16'h7530, 16'hea60};
	typedef enum logic [1:0] {DT_BYTE = 2'b00, DT_WORD = 2'b01, DT_DWORD = 2'b10, DT_CONN = 2'b11} dtype_t;
	typedef struct packed {
		logic [15:0] num;
		logic [2:0] elems;
		dtype_t dtype;
		logic wr;
		logic rst_only;
		logic comm_only;
		logic stop_only;
		logic code_req;
		logic deact;
		logic even;
		logic [31:0] abs_lo;
		logic [31:0] abs_hi;
		logic [31:0] cur_lo;
		logic [31:0] cur_hi;
	} attr_t;
	localparam int N_PARAMS = 6;
	localparam int MAX_ELEMS = 4;
	localparam attr_t PARAMS [N_PARAMS] = '{
		{16'h04ba, 3'h0, DT_WORD, 7'h40, 32'h0, 32'h3f, 32'h0, 32'h3f},
		{16'h0348, 3'h3, DT_CONN, 7'h48, 32'h0, 32'hffffffff, 32'h0, 32'hffffffff},
		{16'h1ea1, 3'h3, DT_DWORD, 7'h00, 32'h0, 32'hffffffff, 32'h0, 32'hffffffff},
		{16'h07d1, 3'h0, DT_BYTE, 7'h45, 32'h0, 32'hff, 32'h0a, 32'hc8},
		{16'h1f41, 3'h0, DT_DWORD, 7'h52, 32'h0, 32'h186a0, 32'h0, 32'hc350},
		{16'h03ca, 3'h0, DT_WORD, 7'h60, 32'h0, 32'h1, 32'h0, 32'h1}};
	typedef enum logic [1:0] {DEV_IDLE = 2'b00, DEV_CHECK = 2'b01, DEV_RESP = 2'b10} dev_state_t;
	typedef enum logic [1:0] {HOST_IDLE = 2'b00, HOST_SEND = 2'b01, HOST_WAIT = 2'b10} host_state_t;
endpackage : param_channel_pkg

/* design/param_channel_if.sv */
`timescale 1ns/1ps
interface param_channel_if;
	logic req_valid;
	logic req_ready;
	logic [15:0] req_header;
	logic [15:0] req_index;
	logic [15:0] req_value_high;
	logic [15:0] req_value_low;
	logic rsp_valid;
	logic rsp_ready;
	logic [15:0] rsp_header;
	logic [15:0] rsp_index;
	logic [15:0] rsp_value_high;
	logic [15:0] rsp_value_low;
	modport device(input req_valid, req_header, req_index, req_value_high, req_value_low, rsp_ready,
		output req_ready, rsp_valid, rsp_header, rsp_index, rsp_value_high, rsp_value_low);
	modport host(output req_valid, req_header, req_index, req_value_high, req_value_low, rsp_ready,
		input req_ready, rsp_valid, rsp_header, rsp_index, rsp_value_high, rsp_value_low);
endinterface : param_channel_if

/* design/param_number_codec.sv */
`timescale 1ns/1ps
module param_number_codec import param_channel_pkg::*; (
	input wire logic [10:0] pnu_i,
	input wire logic [7:0] page_i,
	input wire logic [15:0] num_i,
	output logic [15:0] num_o,
	output logic num_ok_o,
	output logic [10:0] pnu_o,
	output logic [7:0] page_o,
	output logic pnu_ok_o
);
	logic [PAGE_COUNT-1:0] dec_hit;
	logic [PAGE_COUNT-1:0] enc_hit;
	logic [15:0] dec_term [PAGE_COUNT];
	logic [15:0] enc_term [PAGE_COUNT];
	logic [7:0] page_term [PAGE_COUNT];
	genvar g;
	generate
		for (g = 0; g < PAGE_COUNT; g++) begin : g_page
			logic [15:0] offs;
			assign offs = num_i - PAGE_BASE[g];
			assign dec_hit[g] = (page_i == PAGE_CODE[g]) && (pnu_i <= PNU_MAX); // R18
			assign enc_hit[g] = (num_i >= PAGE_BASE[g]) && (offs <= {5'h00, PNU_MAX}); // R18
			assign dec_term[g] = dec_hit[g] ? PAGE_BASE[g] + {5'h00, pnu_i} : 16'h0000;
			assign enc_term[g] = enc_hit[g] ? offs : 16'h0000;
			assign page_term[g] = enc_hit[g] ? PAGE_CODE[g] : 8'h00;
		end
	endgenerate
	always_comb begin
		num_o = 16'h0000;
		pnu_o = 11'h000;
		page_o = 8'h00;
		for (int i = 0; i < PAGE_COUNT; i++) begin
			num_o = num_o | dec_term[i];
			pnu_o = pnu_o | enc_term[i][10:0];
			page_o = page_o | page_term[i];
		end
	end
	assign num_ok_o = |dec_hit;
	assign pnu_ok_o = |enc_hit;
endmodule : param_number_codec

/* design/param_channel_host.sv */
`timescale 1ns/1ps
module param_channel_host import param_channel_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	param_channel_if.host ch,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_task_i,
	input wire logic [15:0] cmd_num_i,
	input wire logic [7:0] cmd_sub_i,
	input wire dtype_t cmd_format_i,
	input wire logic [31:0] cmd_value_i,
	output logic cmd_ready_o,
	output logic bad_num_o,
	output logic res_valid_o,
	output logic [3:0] res_task_o,
	output logic [7:0] res_error_o,
	output logic [31:0] res_value_o
);
	host_state_t state_reg, state_next;
	logic cmd_ready_reg, bad_num_reg, res_valid_reg, req_valid_reg, rsp_ready_reg;
	logic [15:0] hdr_reg, idx_reg, vh_reg, vl_reg;
	logic [3:0] res_task_reg;
	logic [7:0] res_error_reg;
	logic [31:0] res_value_reg;
	logic [10:0] param_number_field;
	logic [7:0] page;
	logic pnu_ok;
	param_number_codec u_codec (
		.pnu_i(11'h000),
		.page_i(8'h00),
		.num_i(cmd_num_i),
		.num_o(),
		.num_ok_o(),
		.pnu_o(param_number_field),
		.page_o(page),
		.pnu_ok_o(pnu_ok)
	);
	logic [31:0] packed_val;
	always_comb begin
		unique case (cmd_format_i)
			DT_BYTE: packed_val = {24'h000000, cmd_value_i[7:0]}; // R20
			DT_WORD: packed_val = {16'h0000, cmd_value_i[15:0]}; // R20
			DT_DWORD: packed_val = cmd_value_i; // R20
			DT_CONN: packed_val = {cmd_value_i[31:16], CONN_TAG, cmd_value_i[9:0]}; // R21
		endcase
	end
	logic cmd_take, req_take, rsp_take;
	assign cmd_take = cmd_valid_i && cmd_ready_reg;
	assign req_take = req_valid_reg && ch.req_ready;
	assign rsp_take = ch.rsp_valid && rsp_ready_reg;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HOST_IDLE: if (cmd_take && pnu_ok) state_next = HOST_SEND;
			HOST_SEND: if (req_take) state_next = HOST_WAIT;
			HOST_WAIT: if (rsp_take) state_next = HOST_IDLE;
			default: state_next = HOST_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= HOST_IDLE;
			cmd_ready_reg <= 1'b0;
			req_valid_reg <= 1'b0;
			rsp_ready_reg <= 1'b0;
			bad_num_reg <= 1'b0;
			res_valid_reg <= 1'b0;
			{hdr_reg, idx_reg, vh_reg, vl_reg} <= 64'h0;
			res_task_reg <= 4'h0;
			res_error_reg <= 8'h00;
			res_value_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			cmd_ready_reg <= (state_next == HOST_IDLE);
			req_valid_reg <= (state_next == HOST_SEND);
			rsp_ready_reg <= (state_next == HOST_WAIT);
			bad_num_reg <= cmd_take && !pnu_ok;
			res_valid_reg <= rsp_take;
			if (cmd_take) begin
				hdr_reg <= {cmd_task_i, 1'b0, param_number_field}; // R23 R18
				idx_reg <= {cmd_sub_i, page}; // R17 R19
				{vh_reg, vl_reg} <= packed_val;
			end
			if (rsp_take) begin
				res_task_reg <= ch.rsp_header[TASK_MSB:TASK_LSB];
				res_value_reg <= {ch.rsp_value_high, ch.rsp_value_low};
				res_error_reg <= (ch.rsp_header[TASK_MSB:TASK_LSB] == RSP_ERROR) ? ch.rsp_value_high[7:0]
					: 8'h00; // R22
			end
		end
	end
	assign ch.req_valid = req_valid_reg;
	assign ch.req_header = hdr_reg;
	assign ch.req_index = idx_reg;
	assign ch.req_value_high = vh_reg;
	assign ch.req_value_low = vl_reg;
	assign ch.rsp_ready = rsp_ready_reg;
	assign cmd_ready_o = cmd_ready_reg;
	assign bad_num_o = bad_num_reg;
	assign res_valid_o = res_valid_reg;
	assign res_task_o = res_task_reg;
	assign res_error_o = res_error_reg;
	assign res_value_o = res_value_reg;
endmodule : param_channel_host

/* dv/param_channel_assertions.sv */
`timescale 1ns/1ps
module param_channel_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [15:0] req_header,
	input wire logic [15:0] req_index,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [15:0] rsp_header,
	input wire logic [15:0] rsp_index,
	input wire logic [15:0] rsp_value_high,
	input wire logic [15:0] rsp_value_low
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [15:0] hdr_reg;
	logic [15:0] idx_reg;
	wire take = req_valid && req_ready;
	////////////////////////////////////////////////////////////////
	// last request taken, for echo checks
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hdr_reg <= 16'h0000;
			idx_reg <= 16'h0000;
		end else if (take) begin
			hdr_reg <= req_header;
			idx_reg <= req_index;
		end
	end
	////////////////////////////////////////////////////////////////
	a_hdr_reserved: assert property (req_valid |-> !req_header[11]) else $error("request bit 11 set");
	a_rsp_latency: assert property (take |=> !rsp_valid ##1 rsp_valid) else $error("response timing wrong");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_header) && $stable(rsp_value_high)
		&& $stable(rsp_value_low)) else $error("response changed before taken");
	a_one_rsp: assert property (rsp_valid && rsp_ready |=> !rsp_valid [*2]) else $error("extra response");
	a_no_overlap: assert property (rsp_valid |-> !req_ready) else $error("request accepted while answering");
	a_err_layout: assert property (rsp_valid && rsp_header[15:12] == 4'h7 |-> rsp_value_high[15:8] == 8'h00
		&& rsp_value_low == 16'h0000) else $error("error response layout wrong");
	a_echo_words: assert property (rsp_valid |-> rsp_index == idx_reg && rsp_header[10:0] == hdr_reg[10:0]
		&& !rsp_header[11]) else $error("response does not echo request");
	a_bad_task: assert property (rsp_valid && hdr_reg[15:12] > 4'h9 |-> rsp_header[15:12] == 4'h7
		&& rsp_value_high == 16'h006a) else $error("unsupported task not refused");
	a_write_id: assert property (rsp_valid && hdr_reg[15:12] == 4'h2 |-> rsp_header[15:12] inside {4'h1, 4'h7})
		else $error("word change answered with wrong id");
endmodule : param_channel_assertions

/* dv/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; \
	if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb import param_channel_pkg::*;;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic kh = 1'b0, mc = 1'b1, den = 1'b0, busy = 1'b0, kw = 1'b1, code = 1'b1, alt = 1'b0;
	logic [7:0] comm = 8'h0f;
	logic cv = 1'b0;
	logic [3:0] ct = 4'h0;
	logic [15:0] cn = 16'h0000;
	logic [7:0] cs = 8'h00;
	dtype_t cf = DT_WORD;
	logic [31:0] cval = 32'h0;
	logic cmd_ready_o, bad_num_o, res_valid_o, write_pulse_o;
	logic [3:0] res_task_o;
	logic [7:0] res_error_o, last_error_o;
	logic [31:0] res_value_o;
	logic [15:0] cap_h, cap_i, cap_vh, cap_vl;
	int n_fail = 0, compares = 0, cycles = 0, wp_cnt = 0;
	always #2.5 clk_i = ~clk_i;
	param_channel_if param_channel_if_inst();
	param_channel_device param_channel_device_inst (.clk_i(clk_i), .rst_i(rst_i), .ch(param_channel_if_inst.device),
		.know_how_lock_i(kh), .master_control_setting_i(mc), .commissioning_state_setting_i(comm),
		.drive_enabled_i(den), .op_state_busy_i(busy), .keyword_present_i(kw), .access_code_ok_i(code),
		.alt_mode_i(alt), .last_error_o(last_error_o), .write_pulse_o(write_pulse_o));
	param_channel_host param_channel_host_inst (.clk_i(clk_i), .rst_i(rst_i), .ch(param_channel_if_inst.host),
		.cmd_valid_i(cv), .cmd_task_i(ct), .cmd_num_i(cn), .cmd_sub_i(cs), .cmd_format_i(cf), .cmd_value_i(cval),
		.cmd_ready_o(cmd_ready_o), .bad_num_o(bad_num_o), .res_valid_o(res_valid_o), .res_task_o(res_task_o),
		.res_error_o(res_error_o), .res_value_o(res_value_o));
	param_channel_assertions param_channel_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
		.req_valid(param_channel_if_inst.req_valid), .req_ready(param_channel_if_inst.req_ready),
		.req_header(param_channel_if_inst.req_header), .req_index(param_channel_if_inst.req_index),
		.rsp_valid(param_channel_if_inst.rsp_valid), .rsp_ready(param_channel_if_inst.rsp_ready),
		.rsp_header(param_channel_if_inst.rsp_header), .rsp_index(param_channel_if_inst.rsp_index),
		.rsp_value_high(param_channel_if_inst.rsp_value_high), .rsp_value_low(param_channel_if_inst.rsp_value_low));
	////////////////////////////////////////////////////////////////
	// wire capture, pulse count, hang guard
	always @(posedge clk_i) begin
		if (param_channel_if_inst.req_valid === 1'b1 && param_channel_if_inst.req_ready === 1'b1) begin
			cap_h = param_channel_if_inst.req_header;
			cap_i = param_channel_if_inst.req_index;
			cap_vh = param_channel_if_inst.req_value_high;
			cap_vl = param_channel_if_inst.req_value_low;
		end
		if (write_pulse_o === 1'b1) wp_cnt++;
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	// page split from the package tables
	function automatic logic [18:0] split(input logic [15:0] n);
		logic [15:0] d;
		for (int i = 0; i < PAGE_COUNT; i++) begin
			d = n - PAGE_BASE[i];
			if (n >= PAGE_BASE[i] && d < 16'd2000) return {PAGE_CODE[i], d[10:0]};
		end
		return 19'h0;
	endfunction : split
	task automatic cmd(input logic [3:0] t, input logic [15:0] n, input logic [7:0] s, input dtype_t f,
		input logic [31:0] v, input logic [3:0] eid, input logic [7:0] eerr, input logic [31:0] eval);
		int k;
		int w0;
		logic [18:0] sp;
		logic [31:0] pv;
		w0 = wp_cnt;
		sp = split(n);
		pv = (f == DT_BYTE) ? {24'h0, v[7:0]} : (f == DT_WORD) ? {16'h0, v[15:0]} :
			(f == DT_DWORD) ? v : {v[31:16], 6'h3f, v[9:0]};
		{ct, cn, cs, cval, cv} = {t, n, s, v, 1'b1};
		cf = f;
		k = 0;
		while (cmd_ready_o !== 1'b1 && k < 50) begin
			@(negedge clk_i);
			k++;
		end
		@(negedge clk_i);
		cv = 1'b0;
		k = 0;
		while (res_valid_o !== 1'b1 && k < 50) begin
			@(negedge clk_i);
			k++;
		end
		`CHK("header", {t, 1'b0, sp[10:0]}, cap_h)
		`CHK("index", {s, sp[18:11]}, cap_i)
		if (t inside {4'h2, 4'h3, 4'h7, 4'h8}) `CHK("value", pv, {cap_vh, cap_vl})
		`CHK("id", eid, res_task_o)
		`CHK("error", (eid == 4'h7) ? eerr : 8'h00, res_error_o)
		`CHK("result", (eid == 4'h7) ? {8'h00, eerr, 16'h0000} : eval, res_value_o)
		if (eid == 4'h7) `CHK("last_error", eerr, last_error_o)
		`CHK("pulses", (t inside {4'h2, 4'h3, 4'h7, 4'h8} && eid != 4'h7) ? 1 : 0, wp_cnt - w0)
	endtask : cmd
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		cmd(4'h1, 16'd1210, 8'h00, DT_WORD, 32'h0, 4'h1, 8'h00, 32'h0);
		cmd(4'h2, 16'd1210, 8'h00, DT_WORD, 32'h1a, 4'h1, 8'h00, 32'h1a);
		cmd(4'h1, 16'd1210, 8'h00, DT_WORD, 32'h0, 4'h1, 8'h00, 32'h1a);
		cmd(4'h2, 16'd1210, 8'h00, DT_WORD, 32'h40, 4'h7, 8'h02, 32'h0);
		cmd(4'h1, 16'd1211, 8'h00, DT_WORD, 32'h0, 4'h7, 8'h00, 32'h0);
		cmd(4'h8, 16'd7841, 8'h00, DT_DWORD, 32'h5, 4'h7, 8'h01, 32'h0);
		cmd(4'h6, 16'd7841, 8'h02, DT_DWORD, 32'h0, 4'h5, 8'h00, 32'h0);
		cmd(4'h6, 16'd7841, 8'h03, DT_DWORD, 32'h0, 4'h7, 8'h03, 32'h0);
		cmd(4'h9, 16'd7841, 8'h00, DT_DWORD, 32'h0, 4'h6, 8'h00, 32'h3);
		cmd(4'h6, 16'd1210, 8'h01, DT_WORD, 32'h0, 4'h7, 8'h04, 32'h0);
		cmd(4'h3, 16'd1210, 8'h00, DT_DWORD, 32'h1, 4'h7, 8'h05, 32'h0);
		cmd(4'h2, 16'd970, 8'h00, DT_WORD, 32'h1, 4'h7, 8'h06, 32'h0);
		cmd(4'h2, 16'd970, 8'h00, DT_WORD, 32'h0, 4'h1, 8'h00, 32'h0);
		cmd(4'h5, 16'd1210, 8'h00, DT_WORD, 32'h0, 4'h7, 8'h07, 32'h0);
		cmd(4'h4, 16'd1210, 8'h01, DT_WORD, 32'h0, 4'h3, 8'h00, 32'h3f);
		cmd(4'h4, 16'd1210, 8'h02, DT_WORD, 32'h0, 4'h7, 8'h66, 32'h0);
		mc = 1'b0;
		cmd(4'h2, 16'd1210, 8'h00, DT_WORD, 32'h1, 4'h7, 8'h0b, 32'h0);
		{mc, kw} = 2'b10;
		cmd(4'h2, 16'd1210, 8'h00, DT_WORD, 32'h1, 4'h7, 8'h0c, 32'h0);
		{kw, busy} = 2'b11;
		cmd(4'h1, 16'd1210, 8'h00, DT_WORD, 32'h0, 4'h7, 8'h11, 32'h0);
		busy = 1'b0;
		cmd(4'h2, 16'd2001, 8'h00, DT_BYTE, 32'h0b, 4'h7, 8'h14, 32'h0);
		cmd(4'h2, 16'd2001, 8'h00, DT_BYTE, 32'h08, 4'h7, 8'hc8, 32'h0);
		cmd(4'h2, 16'd2001, 8'h00, DT_BYTE, 32'hca, 4'h7, 8'hc9, 32'h0);
		code = 1'b0;
		cmd(4'h2, 16'd2001, 8'h00, DT_BYTE, 32'h10, 4'h7, 8'hcc, 32'h0);
		code = 1'b1;
		cmd(4'h2, 16'd2001, 8'h00, DT_BYTE, 32'h10, 4'h1, 8'h00, 32'h10);
		alt = 1'b1;
		cmd(4'h1, 16'd8001, 8'h00, DT_DWORD, 32'h0, 4'h7, 8'h65, 32'h0);
		{alt, comm} = 9'h000;
		cmd(4'h3, 16'd8001, 8'h00, DT_DWORD, 32'h100, 4'h7, 8'h86, 32'h0);
		comm = 8'h0f;
		cmd(4'h3, 16'd8001, 8'h00, DT_DWORD, 32'h100, 4'h2, 8'h00, 32'h100);
		cmd(4'ha, 16'd1210, 8'h00, DT_WORD, 32'h0, 4'h7, 8'h6a, 32'h0);
		cmd(4'h0, 16'd1210, 8'h00, DT_WORD, 32'h0, 4'h0, 8'h00, 32'h0);
		cmd(4'h7, 16'd840, 8'h01, DT_CONN, 32'h02d20002, 4'h4, 8'h00, 32'h02d2fc02);
		cmd(4'h6, 16'd840, 8'h01, DT_CONN, 32'h0, 4'h5, 8'h00, 32'h02d2fc02);
		den = 1'b1;
		cmd(4'h7, 16'd840, 8'h01, DT_CONN, 32'h02d20002, 4'h7, 8'h6b, 32'h0);
		{den, kh} = 2'b01;
		cmd(4'h1, 16'd1211, 8'h00, DT_WORD, 32'h0, 4'h7, 8'h87, 32'h0);
		kh = 1'b0;
		{ct, cn, cv} = {4'h1, 16'd4000, 1'b1};
		@(negedge clk_i);
		cv = 1'b0;
		`CHK("bad_num", 1'b1, bad_num_o)
		repeat (8) @(negedge clk_i);
		final_report();
	end
endmodule : tb
